/* hw/dds_port_device.sv */
/*
  Control port of the synthesizer: serial shifter on the serial clock, buffered and
  active registers, commit logic, sync clock and pin controls on the system clock.
  Assumes the host keeps chip select low at least 4 system clocks before the first
  serial clock edge, and that all pins are asynchronous to clk_in.
*/
`timescale 1ns/10ps

// Operation
// [RULE1] Commit rising edge copies buffer to active.
// [RULE2] Host moves commit in step with sync.
// [RULE3] Oscillator select pin enables or bypasses oscillator.
// [RULE4] Hardware reset forces registers to initial values.
// [RULE5] Port abort resets serial controller asynchronously.
// [RULE6] After abort, next bit starts new transfer.
// [RULE7] Three-wire reads use serial out pin.
// [RULE8] Transfers count only while chip select low.
// [RULE9] Host makes serial clock; shifting uses it.
// [RULE10] Two-wire reads drive the data line.
// [RULE11] Followers take sync from master sync clock.
// [RULE12] Device drives sync clock for external logic.
// [RULE13] Keying level sampled on sync clock sets ramp.
// [RULE14] Host holds keying low when keying off.
// [RULE15] Power-down pin with register picks sleep mode.
// [RULE16] Host holds hardware reset five clocks.
// [RULE17] Sync clock is quarter system clock.
// [RULE18] Frequency/phase after 24, amplitude after 16.
// [RULE19] Serial writes wait in buffer until commit.
module dds_port_device #(
  parameter int FREQ_LAT = dds_port_pkg::FREQ_LATENCY,
  parameter int AMP_LAT = dds_port_pkg::AMP_LATENCY
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Pins facing the host
  dds_port_if.device_mp link,
  // Synthesizer core controls
  output logic [31:0] freq_word_out,
  output logic [13:0] phase_word_out,
  output logic [13:0] amplitude_out,
  output logic keying_up_out,
  output logic osc_enable_out,
  output logic full_sleep_out,
  output logic rapid_pd_out
);

  localparam int DIV_BITS = $clog2(dds_port_pkg::SYNC_DIV);

  if (FREQ_LAT < 2 || AMP_LAT < 2 || AMP_LAT > FREQ_LAT)
  begin : bad_latency
    $error("Latencies must be at least 2 and amplitude must not exceed frequency.");
  end
  if (dds_port_pkg::SYNC_DIV != 4)
  begin : bad_divider
    $error("Sync divider must be four.");
  end

  // ==========================================================================
  // Serial clock domain
  logic frame_rst_b;
  logic [5:0] bit_count;
  logic [7:0] instr;
  logic [30:0] shift;
  logic wr_toggle;
  logic [1:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] mirror [dds_port_pkg::REG_COUNT];
  logic in_instr;
  logic in_data;
  logic reading;
  logic read_phase;
  logic three_wire;
  logic [4:0] bit_index;
  logic [31:0] read_word;
  logic read_bit;

  // Chip select high, abort or reset clears the frame at once.
  assign frame_rst_b = rst_b_in & ~link.cs_b & ~link.port_abort; // RULE5 RULE8
  assign in_instr = bit_count < dds_port_pkg::INSTR_BITS;
  assign in_data = !in_instr && bit_count <= dds_port_pkg::FRAME_LAST;
  assign reading = instr[dds_port_pkg::READ_FLAG_POS];
  assign read_phase = reading && in_data;
  assign three_wire = mirror[dds_port_pkg::REG_CTRL][dds_port_pkg::CTRL_THREE_WIRE_POS];
  assign bit_index = 5'(dds_port_pkg::FRAME_LAST - bit_count);
  assign read_word = mirror[instr[1:0]];
  assign read_bit = read_word[bit_index];

  // Bits are taken on the rising serial clock edge.
  always_ff @(posedge link.sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      bit_count <= 6'h00; // RULE6
      instr <= 8'h00;
      shift <= 31'h0000_0000;
    end
    else
    begin
      if (bit_count <= dds_port_pkg::FRAME_LAST)
        bit_count <= bit_count + 6'h01; // RULE9
      if (in_instr)
        instr <= {instr[6:0], link.sdio};
      else if (in_data)
        shift <= {shift[29:0], link.sdio};
    end
  end

  // A finished write is held steady and announced by a toggle.
  always_ff @(posedge link.sclk or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_toggle <= 1'b0;
      wr_addr <= 2'h0;
      wr_data <= 32'h0000_0000;
    end
    else if (frame_rst_b && !reading && bit_count == dds_port_pkg::FRAME_LAST)
    begin
      wr_toggle <= ~wr_toggle;
      wr_addr <= instr[1:0];
      wr_data <= {shift, link.sdio};
    end
  end

  // Read bits are launched on the falling edge; the host takes each one at its next falling edge.
  always_ff @(negedge link.sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      link.sdio_dev <= 1'b0;
      link.sdio_dev_oe_b <= 1'b1;
      link.serial_out_pin <= 1'b0;
      link.serial_out_oe_b <= 1'b1;
    end
    else
    begin
      link.sdio_dev <= read_bit;
      link.sdio_dev_oe_b <= ~(read_phase & ~three_wire); // RULE10
      link.serial_out_pin <= read_bit;
      link.serial_out_oe_b <= ~(read_phase & three_wire); // RULE7
    end
  end

  // ==========================================================================
  // Pin synchronisers on the system clock
  logic [7:0] pin_raw;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_last;
  logic write_seen;
  logic commit_rise;
  logic sync_rise;
  logic hw_reset;

  assign pin_raw = {wr_toggle, link.sync_in, link.powerdown_pin, link.oscillator_select,
                    link.keying_direction, link.cs_b, link.hw_reset, link.commit};
  assign write_seen = pin_sync[dds_port_pkg::PIN_TGL] ^ pin_last[dds_port_pkg::PIN_TGL];
  assign commit_rise = pin_sync[dds_port_pkg::PIN_COMMIT] & ~pin_last[dds_port_pkg::PIN_COMMIT];
  assign sync_rise = pin_sync[dds_port_pkg::PIN_SYNC] & ~pin_last[dds_port_pkg::PIN_SYNC];
  assign hw_reset = pin_sync[dds_port_pkg::PIN_HWRST];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_meta <= dds_port_pkg::PIN_RESET;
      pin_sync <= dds_port_pkg::PIN_RESET;
      pin_last <= dds_port_pkg::PIN_RESET;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // ==========================================================================
  // Buffered, active and mirrored registers
  logic [31:0] buffer [dds_port_pkg::REG_COUNT];
  logic [31:0] active [dds_port_pkg::REG_COUNT];
  logic [31:0] ctrl;
  logic sync_en;

  assign ctrl = active[dds_port_pkg::REG_CTRL];
  assign sync_en = active[dds_port_pkg::REG_AUX][dds_port_pkg::AUX_SYNC_EN_POS];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < dds_port_pkg::REG_COUNT; i++)
      begin
        buffer[i] <= dds_port_pkg::reset_value(2'(i));
        active[i] <= dds_port_pkg::reset_value(2'(i));
      end
    end
    else if (hw_reset)
    begin
      for (int i = 0; i < dds_port_pkg::REG_COUNT; i++)
      begin
        buffer[i] <= dds_port_pkg::reset_value(2'(i)); // RULE4
        active[i] <= dds_port_pkg::reset_value(2'(i)); // RULE4
      end
    end
    else
    begin
      if (write_seen)
        buffer[wr_addr] <= wr_data; // RULE19
      if (commit_rise)
      begin
        for (int i = 0; i < dds_port_pkg::REG_COUNT; i++)
          active[i] <= buffer[i]; // RULE1
      end
    end
  end

  // The mirror freezes while chip select is low so reads see a steady word.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < dds_port_pkg::REG_COUNT; i++)
        mirror[i] <= dds_port_pkg::reset_value(2'(i));
    end
    else if (pin_sync[dds_port_pkg::PIN_CS])
    begin
      for (int i = 0; i < dds_port_pkg::REG_COUNT; i++)
        mirror[i] <= active[i];
    end
  end

  // ==========================================================================
  // Sync clock, keying, latency and power-down
  logic [DIV_BITS-1:0] div;
  logic [DIV_BITS-1:0] next_div;
  logic [FREQ_LAT-1:0] commit_pipe;
  logic [31:0] pa_word;

  // A master's sync clock on sync_in realigns the divider when enabled.
  assign next_div = (sync_en && sync_rise) ? '0 : div + 1'b1; // RULE11
  assign pa_word = active[dds_port_pkg::REG_PHASE_AMP];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      // The divider starts on its last count so the first sync period is whole.
      div <= '1;
      link.sync_clk <= 1'b0;
      keying_up_out <= 1'b0;
    end
    else
    begin
      div <= next_div;
      link.sync_clk <= ~next_div[DIV_BITS-1]; // RULE12 RULE17
      if (next_div == '0)
        keying_up_out <= ctrl[dds_port_pkg::CTRL_KEYING_EN_POS]
                         & pin_sync[dds_port_pkg::PIN_KEY]; // RULE13
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      commit_pipe <= '0;
      freq_word_out <= dds_port_pkg::FREQ_RESET;
      phase_word_out <= dds_port_pkg::PHASE_AMP_RESET[dds_port_pkg::PHASE_LSB +: 14];
      amplitude_out <= dds_port_pkg::PHASE_AMP_RESET[dds_port_pkg::AMP_LSB +: 14];
    end
    else if (hw_reset)
    begin
      commit_pipe <= '0;
      freq_word_out <= dds_port_pkg::FREQ_RESET;
      phase_word_out <= dds_port_pkg::PHASE_AMP_RESET[dds_port_pkg::PHASE_LSB +: 14];
      amplitude_out <= dds_port_pkg::PHASE_AMP_RESET[dds_port_pkg::AMP_LSB +: 14];
    end
    else
    begin
      commit_pipe <= {commit_pipe[FREQ_LAT-2:0], commit_rise};
      if (commit_pipe[FREQ_LAT-1])
      begin
        freq_word_out <= active[dds_port_pkg::REG_FREQ]; // RULE18
        phase_word_out <= pa_word[dds_port_pkg::PHASE_LSB +: 14]; // RULE18
      end
      if (commit_pipe[AMP_LAT-1])
        amplitude_out <= pa_word[dds_port_pkg::AMP_LSB +: 14]; // RULE18
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      osc_enable_out <= 1'b0;
      full_sleep_out <= 1'b0;
      rapid_pd_out <= 1'b0;
    end
    else
    begin
      osc_enable_out <= pin_sync[dds_port_pkg::PIN_OSC]; // RULE3
      full_sleep_out <= pin_sync[dds_port_pkg::PIN_PD]
                        & ~ctrl[dds_port_pkg::CTRL_PD_RAPID_POS]; // RULE15
      rapid_pd_out <= pin_sync[dds_port_pkg::PIN_PD]
                      & ctrl[dds_port_pkg::CTRL_PD_RAPID_POS]; // RULE15
    end
  end

endmodule : dds_port_device

/* hw/dds_port_host.sv */
/*
  Host controller for the synthesizer control port: serial frames, commit strobe,
  abort, hardware reset and level pins. The serial clock is divided from clk_in.
  Assumes the device answers through dds_port_if; its pins are asynchronous here.
*/
`timescale 1ns/10ps
module dds_port_host #(
  parameter int SCLK_HALF = dds_port_pkg::SCLK_HALF_CYCLES
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Pins facing the device
  dds_port_if.host_mp link,
  // Register requests
  input wire logic req_valid_in,
  input wire logic req_read_in,
  input wire logic [1:0] req_addr_in,
  input wire logic [31:0] req_data_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  // Pin controls
  input wire logic three_wire_in,
  input wire logic commit_req_in,
  input wire logic abort_req_in,
  input wire logic hw_reset_req_in,
  input wire logic keying_in,
  input wire logic powerdown_in,
  input wire logic osc_select_in
);

  localparam int HALF_BITS = $clog2(SCLK_HALF) + 1;

  if (SCLK_HALF < 4)
  begin : bad_half
    $error("Serial clock half period must be at least 4 cycles.");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } host_state_type;

  // ==========================================================================
  // Input synchronisers and pulse counters
  logic [2:0] in_meta;
  logic [2:0] in_sync;
  logic sync_last;
  logic sync_fall;
  logic rx_pin;
  logic [2:0] abort_cnt;
  logic [2:0] next_abort_cnt;
  logic [2:0] rst_cnt;
  logic [2:0] next_rst_cnt;
  logic commit_pend;

  assign sync_fall = sync_last & ~in_sync[dds_port_pkg::HIN_SCLK];
  assign rx_pin = three_wire_in ? in_sync[dds_port_pkg::HIN_SO] : in_sync[dds_port_pkg::HIN_SDIO];
  assign next_abort_cnt = abort_req_in ? 3'(dds_port_pkg::ABORT_HOLD_CYCLES)
                        : (abort_cnt != 3'h0 ? abort_cnt - 3'h1 : 3'h0);
  assign next_rst_cnt = hw_reset_req_in ? 3'(dds_port_pkg::RESET_HOLD_CYCLES)
                      : (rst_cnt != 3'h0 ? rst_cnt - 3'h1 : 3'h0);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      in_meta <= 3'h0;
      in_sync <= 3'h0;
      sync_last <= 1'b0;
      abort_cnt <= 3'h0;
      rst_cnt <= 3'h0;
      commit_pend <= 1'b0;
      link.commit <= 1'b0;
      link.keying_direction <= 1'b0;
      link.port_abort <= 1'b0;
      link.hw_reset <= 1'b0;
      link.powerdown_pin <= 1'b0;
      link.oscillator_select <= 1'b0;
    end
    else
    begin
      in_meta <= {link.sync_clk, link.serial_out_pin, link.sdio};
      in_sync <= in_meta;
      sync_last <= in_sync[dds_port_pkg::HIN_SCLK];
      abort_cnt <= next_abort_cnt;
      rst_cnt <= next_rst_cnt;
      link.port_abort <= next_abort_cnt != 3'h0;
      link.hw_reset <= next_rst_cnt != 3'h0; // RULE16
      link.powerdown_pin <= powerdown_in;
      link.oscillator_select <= osc_select_in;
      // A new request wins over the clear of the pending commit.
      commit_pend <= commit_req_in | (commit_pend & ~(sync_fall & ~link.commit));
      if (sync_fall)
      begin
        link.commit <= commit_pend & ~link.commit; // RULE2
        link.keying_direction <= keying_in; // RULE14
      end
    end
  end

  // ==========================================================================
  // Serial frame engine
  host_state_type state;
  logic [HALF_BITS-1:0] half_cnt;
  logic half_end;
  logic [5:0] bit_cnt;
  logic [39:0] frame;
  logic [31:0] rx;
  logic reading;

  assign half_end = half_cnt == HALF_BITS'(SCLK_HALF - 1);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_IDLE;
      half_cnt <= '0;
      bit_cnt <= 6'h00;
      frame <= 40'h00_0000_0000;
      rx <= 32'h0000_0000;
      reading <= 1'b0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 32'h0000_0000;
      link.cs_b <= 1'b1;
      link.sclk <= 1'b0;
      link.sdio_host <= 1'b0;
      link.sdio_host_oe_b <= 1'b1;
    end
    else if (abort_req_in || link.port_abort)
    begin
      state <= ST_IDLE;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      link.cs_b <= 1'b1;
      link.sclk <= 1'b0;
      link.sdio_host_oe_b <= 1'b1;
    end
    else
    begin
      rsp_valid_out <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          req_ready_out <= ~(req_valid_in & req_ready_out);
          if (req_valid_in && req_ready_out)
          begin
            frame <= {req_read_in, dds_port_pkg::INSTR_PAD, req_addr_in, req_data_in};
            reading <= req_read_in;
            half_cnt <= '0;
            bit_cnt <= 6'h00;
            link.cs_b <= 1'b0;
            link.sdio_host <= req_read_in;
            link.sdio_host_oe_b <= 1'b0;
            state <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          half_cnt <= half_end ? '0 : half_cnt + 1'b1;
          if (half_end)
          begin
            link.sclk <= 1'b1; // RULE9
            state <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          half_cnt <= half_end ? '0 : half_cnt + 1'b1;
          if (half_end)
          begin
            link.sclk <= 1'b0;
            rx <= {rx[30:0], rx_pin};
            if (bit_cnt == dds_port_pkg::FRAME_LAST)
            begin
              link.cs_b <= 1'b1;
              link.sdio_host_oe_b <= 1'b1;
              rsp_valid_out <= reading;
              rsp_data_out <= {rx[30:0], rx_pin};
              state <= ST_IDLE;
            end
            else
            begin
              bit_cnt <= bit_cnt + 6'h01;
              frame <= {frame[38:0], 1'b0};
              link.sdio_host <= frame[38];
              link.sdio_host_oe_b <= reading && (bit_cnt + 6'h01) >= dds_port_pkg::INSTR_BITS;
              state <= ST_LOW;
            end
          end
        end
      endcase
    end
  end

endmodule : dds_port_host

/* hw/dds_port_if.sv */
/*
  Pin bundle between the host controller and the synthesizer control port.
  Assumes the bench drives sync_in; the shared data line is resolved here from the enables.
*/
`timescale 1ns/10ps
interface dds_port_if;
  logic cs_b;
  logic sclk;
  logic sdio_host;
  logic sdio_host_oe_b;
  logic sdio_dev;
  logic sdio_dev_oe_b;
  logic sdio;
  logic serial_out_pin;
  logic serial_out_oe_b;
  logic commit;
  logic port_abort;
  logic hw_reset;
  logic powerdown_pin;
  logic keying_direction;
  logic oscillator_select;
  logic sync_clk;
  logic sync_in;

  // Undriven data line floats high through a pull-up.
  assign sdio = !sdio_dev_oe_b ? sdio_dev : (!sdio_host_oe_b ? sdio_host : 1'b1);

  modport device_mp (
    input cs_b, sclk, sdio, commit, port_abort, hw_reset, powerdown_pin,
    input keying_direction, oscillator_select, sync_in,
    output sdio_dev, sdio_dev_oe_b, serial_out_pin, serial_out_oe_b, sync_clk
  );

  modport host_mp (
    output cs_b, sclk, sdio_host, sdio_host_oe_b, commit, port_abort, hw_reset,
    output powerdown_pin, keying_direction, oscillator_select,
    input sdio, serial_out_pin, sync_clk
  );
endinterface : dds_port_if

/* hw/dds_port_pkg.sv */
/*
  Shared constants for the serial control port of the synthesizer and its host controller.
  Assumes both ends run a 200 MHz system clock and meet only through dds_port_if.
*/
package dds_port_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 500;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int RESET_HOLD_CYCLES = 5;
  localparam int ABORT_HOLD_CYCLES = 4;
  localparam int FREQ_LATENCY = 24;
  localparam int AMP_LATENCY = 16;
  localparam int SYNC_DIV = 4;

  // ==========================================================================
  // Serial frame: instruction byte then one 32-bit word, most significant bit first
  localparam int DATA_BITS = 32;
  localparam int REG_COUNT = 4;
  localparam int READ_FLAG_POS = 7;
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] FRAME_LAST = 6'h27;
  localparam logic [4:0] INSTR_PAD = 5'h00;

  // ==========================================================================
  // Register map and fields
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_AUX = 2'h1;
  localparam logic [1:0] REG_FREQ = 2'h2;
  localparam logic [1:0] REG_PHASE_AMP = 2'h3;
  localparam int CTRL_THREE_WIRE_POS = 1;
  localparam int CTRL_KEYING_EN_POS = 2;
  localparam int CTRL_PD_RAPID_POS = 3;
  localparam int AUX_SYNC_EN_POS = 0;
  localparam int PHASE_LSB = 0;
  localparam int AMP_LSB = 16;
  localparam int WORD14_BITS = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] AUX_RESET = 32'h0000_0000;
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [31:0] PHASE_AMP_RESET = 32'h3fff_0000;

  // ==========================================================================
  // Device pin synchroniser slots
  localparam int PIN_COMMIT = 0;
  localparam int PIN_HWRST = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_KEY = 3;
  localparam int PIN_OSC = 4;
  localparam int PIN_PD = 5;
  localparam int PIN_SYNC = 6;
  localparam int PIN_TGL = 7;
  localparam logic [7:0] PIN_RESET = 8'h04;

  // Host input synchroniser slots
  localparam int HIN_SDIO = 0;
  localparam int HIN_SO = 1;
  localparam int HIN_SCLK = 2;

  function automatic logic [31:0] reset_value(input logic [1:0] addr);
    logic [31:0] value;
    value = CTRL_RESET;
    unique case (addr)
      REG_CTRL: value = CTRL_RESET;
      REG_AUX: value = AUX_RESET;
      REG_FREQ: value = FREQ_RESET;
      REG_PHASE_AMP: value = PHASE_AMP_RESET;
    endcase
    return value;
  endfunction : reset_value

endpackage : dds_port_pkg

/* tb/dds_port_monitor.sv */
/*
  Checker for the pins between the host controller and the synthesizer port.
  Assumes a serial clock half period of 4 system clocks.
*/
`timescale 1ns/10ps
module dds_port_monitor (
  // Clock, reset and pins
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic sdio_dev_oe_b,
  input wire logic serial_out_oe_b,
  input wire logic commit,
  input wire logic port_abort,
  input wire logic hw_reset,
  input wire logic sync_clk
);
  // ==========================================================================
  // Pin checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_SYNC_SHAPE: assert property ($rose(sync_clk) |-> ##1 sync_clk ##1 !sync_clk
    ##1 !sync_clk ##1 sync_clk) else $error("sync clock is not a quarter rate");
  AST_SYNC_RUNS: assert property (!sync_clk |-> ##[1:2] sync_clk)
    else $error("sync clock stopped");
  AST_DESELECT: assert property (cs_b |-> sdio_dev_oe_b && serial_out_oe_b)
    else $error("device drives while deselected");
  AST_ABORT: assert property (port_abort |-> sdio_dev_oe_b && serial_out_oe_b)
    else $error("device drives during abort");
  AST_ONE_PIN: assert property (!(!sdio_dev_oe_b && !serial_out_oe_b))
    else $error("device drives both data pins");
  AST_SCLK: assert property (disable iff (!rst_b_in || port_abort)
    $rose(sclk) |-> (!cs_b && sclk)[*4] ##1 !sclk) else $error("serial clock high half wrong");
  AST_HWRST: assert property ($rose(hw_reset) |-> hw_reset[*5])
    else $error("hardware reset too short");
  AST_COMMIT: assert property ($rose(commit) |-> commit[*4])
    else $error("commit shorter than a sync period");
  AST_CS_GAP: assert property ($rose(cs_b) |-> cs_b[*2])
    else $error("chip select gap too short");
  cover property ($rose(commit));
  cover property (!serial_out_oe_b);
  cover property (!sdio_dev_oe_b && !cs_b);
  cover property ($rose(port_abort));
endmodule : dds_port_monitor

/* tb/testbench.sv */
/*
  Self-checking bench: host controller and synthesizer port joined by the pin interface.
  Assumes a shortened serial clock half period of 4 system clocks.
*/
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_read_in = 1'b0;
  logic [1:0] req_addr_in = 2'h0;
  logic [31:0] req_data_in = 32'h0;
  logic three_wire_in = 1'b0;
  logic commit_req_in = 1'b0;
  logic abort_req_in = 1'b0;
  logic hw_reset_req_in = 1'b0;
  logic keying_in = 1'b0;
  logic powerdown_in = 1'b0;
  logic osc_select_in = 1'b0;
  logic req_ready_out, rsp_valid_out, keying_up_out, osc_enable_out, full_sleep_out, rapid_pd_out;
  logic [31:0] rsp_data_out, freq_word_out, rd_data;
  logic [13:0] phase_word_out, amplitude_out;
  int fails = 0;
  int compares = 0;
  dds_port_if link ();
  assign link.sync_in = link.sync_clk;
  dds_port_device dds_port_device_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
    .freq_word_out(freq_word_out), .phase_word_out(phase_word_out), .amplitude_out(amplitude_out),
    .keying_up_out(keying_up_out), .osc_enable_out(osc_enable_out),
    .full_sleep_out(full_sleep_out), .rapid_pd_out(rapid_pd_out));
  dds_port_host #(.SCLK_HALF(4)) dds_port_host_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link(link), .req_valid_in(req_valid_in), .req_read_in(req_read_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .three_wire_in(three_wire_in),
    .commit_req_in(commit_req_in), .abort_req_in(abort_req_in),
    .hw_reset_req_in(hw_reset_req_in), .keying_in(keying_in), .powerdown_in(powerdown_in),
    .osc_select_in(osc_select_in));
  dds_port_monitor dds_port_monitor_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b(link.cs_b),
    .sclk(link.sclk), .sdio_dev_oe_b(link.sdio_dev_oe_b), .serial_out_oe_b(link.serial_out_oe_b),
    .commit(link.commit), .port_abort(link.port_abort), .hw_reset(link.hw_reset),
    .sync_clk(link.sync_clk));

  // ==========================================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic conclude;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic until_ready;
    int n;
    for (n = 0; req_ready_out !== 1'b1; n++)
    begin
      if (n == 9000)
      begin
        fails++;
        conclude();
      end
      tick(1);
    end
  endtask : until_ready

  // A cut frame is aborted in mid data and gives no answer.
  task automatic xfer(input logic rd, input logic [1:0] a, input logic [31:0] d, input logic cut);
    int n;
    until_ready();
    req_valid_in = 1'b1;
    req_read_in = rd;
    req_addr_in = a;
    req_data_in = d;
    tick(1);
    req_valid_in = 1'b0;
    if (cut)
    begin
      tick(100);
      abort_req_in = 1'b1;
      tick(1);
      abort_req_in = 1'b0;
    end
    for (n = 0; rd && rsp_valid_out !== 1'b1; n++)
    begin
      if (n == 9000)
      begin
        fails++;
        conclude();
      end
      tick(1);
    end
    rd_data = rsp_data_out;
    until_ready();
  endtask : xfer

  task automatic commit_now;
    commit_req_in = 1'b1;
    tick(1);
    commit_req_in = 1'b0;
    tick(48);
  endtask : commit_now

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk({freq_word_out, amplitude_out, phase_word_out}, {32'h0, 14'h3fff, 14'h0});
    xfer(1'b1, dds_port_pkg::REG_PHASE_AMP, 32'h0, 1'b0);
    chk(rd_data, dds_port_pkg::PHASE_AMP_RESET);
  endtask : t_reset

  task automatic t_commit;
    int m;
    xfer(1'b0, dds_port_pkg::REG_FREQ, 32'h1234_5678, 1'b0);
    xfer(1'b0, dds_port_pkg::REG_PHASE_AMP, 32'h0abc_0123, 1'b0);
    tick(8);
    chk(freq_word_out, 32'h0);
    commit_req_in = 1'b1;
    tick(1);
    commit_req_in = 1'b0;
    for (m = 0; amplitude_out === 14'h3fff && m < 100; m++)
      tick(1);
    for (m = 0; freq_word_out === 32'h0 && m < 100; m++)
      tick(1);
    chk(m, dds_port_pkg::FREQ_LATENCY - dds_port_pkg::AMP_LATENCY);
    chk({freq_word_out, amplitude_out, phase_word_out}, {32'h1234_5678, 14'h0abc, 14'h0123});
  endtask : t_commit

  task automatic t_wires;
    xfer(1'b0, dds_port_pkg::REG_CTRL, 32'h0000_0002, 1'b0);
    commit_now();
    three_wire_in = 1'b1;
    xfer(1'b1, dds_port_pkg::REG_FREQ, 32'h0, 1'b0);
    chk(rd_data, 32'h1234_5678);
    xfer(1'b0, dds_port_pkg::REG_CTRL, 32'h0, 1'b0);
    commit_now();
    three_wire_in = 1'b0;
    xfer(1'b1, dds_port_pkg::REG_FREQ, 32'h0, 1'b0);
    chk(rd_data, 32'h1234_5678);
  endtask : t_wires

  task automatic t_abort;
    xfer(1'b0, dds_port_pkg::REG_FREQ, 32'hdead_beef, 1'b1);
    commit_now();
    chk(freq_word_out, 32'h1234_5678);
    xfer(1'b0, dds_port_pkg::REG_FREQ, 32'h0000_00ff, 1'b0);
    commit_now();
    chk(freq_word_out, 32'h0000_00ff);
  endtask : t_abort

  task automatic t_pins;
    osc_select_in = 1'b1;
    powerdown_in = 1'b1;
    tick(16);
    chk({osc_enable_out, full_sleep_out, rapid_pd_out}, 3'h6);
    xfer(1'b0, dds_port_pkg::REG_CTRL, 32'h0000_000c, 1'b0);
    commit_now();
    keying_in = 1'b1;
    tick(16);
    chk({keying_up_out, full_sleep_out, rapid_pd_out}, 3'h5);
    keying_in = 1'b0;
    osc_select_in = 1'b0;
    powerdown_in = 1'b0;
    tick(16);
    chk({keying_up_out, osc_enable_out, full_sleep_out, rapid_pd_out}, 4'h0);
  endtask : t_pins

  task automatic t_hwrst;
    hw_reset_req_in = 1'b1;
    tick(1);
    hw_reset_req_in = 1'b0;
    tick(16);
    t_reset();
    xfer(1'b1, dds_port_pkg::REG_CTRL, 32'h0, 1'b0);
    chk(rd_data, dds_port_pkg::CTRL_RESET);
  endtask : t_hwrst

  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end

  initial
  begin
    #1;
    rst_b_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    tick(2);
    t_reset();
    t_commit();
    t_wires();
    t_abort();
    t_pins();
    t_hwrst();
    conclude();
  end
endmodule : testbench
